// ==== hdl/mgs_pkg.sv ====
package mgs_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // clock and interval timing
  localparam int unsigned CLK_PERIOD_NS = 10;
  // interval counter grain, 1 ms
  localparam int unsigned TICK_NS = 1000000;
  localparam int unsigned TICK_CYCLES = TICK_NS / CLK_PERIOD_NS;
  // continuous periods in ms for 10, 20, 50, 100, 200 and 1 Hz
  localparam int unsigned RATE_COUNT = 6;
  localparam logic [9:0] PERIOD_MS [RATE_COUNT] = '{10'h064, 10'h032, 10'h014,
                                                    10'h00A, 10'h005, 10'h3E8};

  ////////////////////////////////////////////////////////////////////////////
  // apb register map, byte addresses
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam logic [7:0] OFF_FIRST_STATUS = 8'h00;
  localparam logic [7:0] OFF_MODE_CONTROL = 8'h04;
  localparam logic [7:0] OFF_SOFT_RESET = 8'h08;
  localparam logic [7:0] OFF_FIRST_DATA = 8'h0C;
  localparam logic [7:0] OFF_Y_DATA = 8'h10;
  localparam logic [7:0] OFF_LAST_AXIS_DATA = 8'h14;
  localparam logic [7:0] OFF_LAST_DATA = 8'h18;
  localparam logic [7:0] OFF_SECOND_STATUS = 8'h1C;

  ////////////////////////////////////////////////////////////////////////////
  // field positions
  localparam int unsigned DATA_READY_BIT = 0;
  localparam int unsigned DATA_OVERRUN_BIT = 1;
  localparam int unsigned OVERFLOW_BIT = 3;
  localparam int unsigned SOFT_RESET_BIT = 0;
  localparam int unsigned MODE_W = 5;

  ////////////////////////////////////////////////////////////////////////////
  // mode codes
  localparam logic [4:0] MODE_POWER_DOWN = 5'h00;
  localparam logic [4:0] MODE_SINGLE = 5'h01;
  localparam logic [4:0] MODE_CONT_FIRST = 5'h02;
  localparam logic [4:0] MODE_CONT_LAST = 5'h0C;
  localparam logic [4:0] MODE_SELF_TEST = 5'h10;

  ////////////////////////////////////////////////////////////////////////////
  // overflow limit: 4912 uT at 0.15 uT per count, rounded up to counts
  localparam int unsigned RANGE_UT_X100 = 491200;
  localparam int unsigned SENS_UT_X100 = 15;
  localparam logic [17:0] OVERFLOW_COUNTS =
    18'((RANGE_UT_X100 + SENS_UT_X100 - 1) / SENS_UT_X100);

  // synchroniser idle values: no supply rise, supply present, pin high
  localparam logic [2:0] PIN_SYNC_RST = 3'h3;

  ////////////////////////////////////////////////////////////////////////////
  // types
  typedef struct packed {
    logic [15:0] x;
    logic [15:0] y;
    logic [15:0] z;
    logic [7:0] temp;
  } mgs_sample_s;

  typedef enum logic [2:0] {
    SEQ_POWER_DOWN = 3'b001,
    SEQ_MEASURE = 3'b010,
    SEQ_SLEEP = 3'b100
  } mgs_seq_e;

endpackage : mgs_pkg

// ==== hdl/mgs_sync.sv ====
`timescale 1ns/10ps
module mgs_sync #(
  parameter int unsigned W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // asynchronous levels in, synchronised out
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  typedef struct packed {
    logic [W-1:0] first;
    logic [W-1:0] second;
  } mgs_sync_s;

  mgs_sync_s s;
  mgs_sync_s next_s;

  // two stages, only the second is visible
  always_comb begin
    next_s.first = d_i;
    next_s.second = s.first;
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      s <= '{first: RST_VAL, second: RST_VAL};
    end else begin
      s <= next_s;
    end
  end

  assign q_o = s.second;

endmodule : mgs_sync

// ==== hdl/mgs_interval_timer.sv ====
`timescale 1ns/10ps
module mgs_interval_timer #(
  parameter int unsigned TICK_CYCLES = mgs_pkg::TICK_CYCLES
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // control
  input wire logic restart_i,
  input wire logic run_i,
  input wire logic [2:0] rate_i,
  // one-cycle pulse per elapsed period
  output logic fire_o
);
  import mgs_pkg::*;

  localparam int unsigned TW = $clog2(TICK_CYCLES + 1);

  typedef struct packed {
    logic [TW-1:0] tick;
    logic [9:0] ms;
    logic fire;
  } mgs_tmr_s;

  mgs_tmr_s s;
  mgs_tmr_s next_s;

  // ms prescaler feeding the period counter
  always_comb begin
    next_s = s;
    next_s.fire = 1'b0;
    if (restart_i || !run_i) begin
      next_s.tick = '0;
      next_s.ms = '0;
    end else if (s.tick == TW'(TICK_CYCLES - 1)) begin
      next_s.tick = '0;
      if (s.ms == PERIOD_MS[rate_i] - 10'h001) begin
        next_s.ms = '0;
        next_s.fire = 1'b1;
      end else begin
        next_s.ms = s.ms + 10'h001;
      end
    end else begin
      next_s.tick = s.tick + TW'(1);
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign fire_o = s.fire;

  a_restart_quiet: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    restart_i |=> !fire_o ##1 !fire_o)
    else $error("timer fired right after restart");

endmodule : mgs_interval_timer

// ==== hdl/mgs_seq.sv ====
// Behaviour
// - reset on core supply rise, interface supply loss, pin low or soft reset
// - interface supply absent holds the device in reset
// - after any reset all registers clear and mode is power-down
// - in power-down registers stay accessible and keep their contents
// - single mode measures once, stores, returns to power-down, sets data ready
// - data or second status read clears data ready; leaving power-down does not
// - data ready pin always equals the data ready flag
// - data registers keep the previous result while measuring
// - continuous codes measure at 10, 20, 50, 100, 200, 1 Hz until stopped
// - between measurements only the interval counter runs, then wakes
// - rewriting a continuous code restarts measuring, keeps status and data
// - continuous data ready rises on entering the sleep after a measurement
// - data read starts a read; data or second status read clears ready and overrun
// - stored data frozen from read start until second status is read
// - unread result at next completion keeps ready and sets overrun
// - unfinished read at next completion drops new result, sets overrun
// - overrun clears at the next read start
// - overflow set when axis magnitude sum reaches 4912 uT, per update
// - self-test code measures internal field, then behaves as single mode
//
// The register addresses and register access over APB are this design's own decisions.
`timescale 1ns/10ps
module mgs_seq #(
  parameter int unsigned TICK_CYCLES = mgs_pkg::TICK_CYCLES
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // apb slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [mgs_pkg::ADDR_W-1:0] paddr_i,
  input wire logic [mgs_pkg::DATA_W-1:0] pwdata_i,
  output logic [mgs_pkg::DATA_W-1:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // reset sources, asynchronous pins
  input wire logic core_supply_rise_i,
  input wire logic vid_ok_i,
  input wire logic reset_pin_n_i,
  // measurement front end
  output logic meas_req_o,
  output logic self_test_o,
  input wire logic meas_done_i,
  input wire mgs_pkg::mgs_sample_s meas_data_i,
  // status pins
  output logic data_ready_pin_o,
  output logic sleep_o
);
  import mgs_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    mgs_seq_e seq;
    logic [MODE_W-1:0] mode;
    logic cont;
    logic [2:0] rate;
    logic data_ready_flag;
    logic data_overrun_flag;
    logic sensor_overflow_flag;
    logic reading;
    logic soft_reset_bit;
    logic restart;
    mgs_sample_s data;
    logic [DATA_W-1:0] prdata;
    logic pready;
    logic pslverr;
    logic meas_req;
    logic self_test;
    logic sleep;
  } mgs_core_s;

  localparam mgs_core_s CORE_RST = '{seq: SEQ_POWER_DOWN, default: '0};

  mgs_core_s s;
  mgs_core_s next_s;

  logic [2:0] pins_s;
  logic dev_rst;
  logic fire;
  logic acc;
  logic wr_acc;
  logic rd_acc;
  logic data_rd;
  logic status2_rd;
  logic mode_wr;
  logic code_cont;
  logic stop_wr;
  logic [4:0] wcode;
  logic [17:0] mag_sum;
  logic [DATA_W-1:0] rdata;
  logic rerr;
  logic [DATA_W-1:0] bus_prdata;
  logic bus_pready;
  logic bus_pslverr;

  ////////////////////////////////////////////////////////////////////////////
  // reset sources

  // pins cross into the clock domain before use
  mgs_sync #(
    .W(3),
    .RST_VAL(PIN_SYNC_RST)
  ) u_pin_sync (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .d_i({core_supply_rise_i, vid_ok_i, reset_pin_n_i}),
    .q_o(pins_s)
  );

  // pin causes hold the device in reset while present; the soft reset bit clears itself after one cycle
  assign dev_rst = pins_s[2] | !pins_s[1] | !pins_s[0] | s.soft_reset_bit;

  ////////////////////////////////////////////////////////////////////////////
  // interval counter

  // runs only while in a continuous mode
  mgs_interval_timer #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_timer (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .restart_i(s.restart),
    .run_i(s.cont && (s.seq != SEQ_POWER_DOWN)),
    .rate_i(s.rate),
    .fire_o(fire)
  );

  ////////////////////////////////////////////////////////////////////////////
  // bus decode

  // effects land on the edge that completes the access
  assign acc = psel_i & penable_i & s.pready;
  assign wr_acc = acc & pwrite_i;
  assign rd_acc = acc & !pwrite_i;
  assign data_rd = rd_acc && ((paddr_i == OFF_FIRST_DATA) || (paddr_i == OFF_Y_DATA) ||
                   (paddr_i == OFF_LAST_AXIS_DATA) || (paddr_i == OFF_LAST_DATA));
  assign status2_rd = rd_acc && (paddr_i == OFF_SECOND_STATUS);
  assign mode_wr = wr_acc && (paddr_i == OFF_MODE_CONTROL);
  assign wcode = pwdata_i[MODE_W-1:0];
  assign code_cont = (wcode >= MODE_CONT_FIRST) && (wcode <= MODE_CONT_LAST) && !wcode[0];
  assign stop_wr = mode_wr && (wcode == MODE_POWER_DOWN);

  // read data mux, unmapped addresses answer with an error
  always_comb begin
    rdata = '0;
    rerr = 1'b0;
    unique case (paddr_i)
      OFF_FIRST_STATUS: begin
        rdata[DATA_READY_BIT] = s.data_ready_flag;
        rdata[DATA_OVERRUN_BIT] = s.data_overrun_flag;
      end
      OFF_MODE_CONTROL: rdata[MODE_W-1:0] = s.mode;
      OFF_SOFT_RESET: rdata = '0;
      OFF_FIRST_DATA: rdata[15:0] = s.data.x;
      OFF_Y_DATA: rdata[15:0] = s.data.y;
      OFF_LAST_AXIS_DATA: rdata[15:0] = s.data.z;
      OFF_LAST_DATA: rdata[7:0] = s.data.temp;
      OFF_SECOND_STATUS: rdata[OVERFLOW_BIT] = s.sensor_overflow_flag;
      default: rerr = 1'b1;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // overflow magnitude

  function automatic logic [16:0] mgs_abs(input logic [15:0] v);
    logic [16:0] w;
    w = {v[15], v};
    return v[15] ? (17'h00000 - w) : w;
  endfunction : mgs_abs

  // sum of axis magnitudes of the incoming sample
  assign mag_sum = 18'(mgs_abs(meas_data_i.x)) + 18'(mgs_abs(meas_data_i.y)) +
                   18'(mgs_abs(meas_data_i.z));

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    next_s = s;
    next_s.restart = 1'b0;
    bus_prdata = '0;
    bus_pready = 1'b0;
    bus_pslverr = 1'b0;
    // two-cycle apb answer, read data latched with ready
    next_s.pready = psel_i & penable_i & !s.pready;
    if (next_s.pready) begin
      next_s.prdata = rdata;
      next_s.pslverr = rerr;
    end
    // read start clears flags, second status ends protection
    if (data_rd || status2_rd) begin
      next_s.data_ready_flag = 1'b0;
      next_s.data_overrun_flag = 1'b0;
      next_s.reading = data_rd;
    end
    if (wr_acc && (paddr_i == OFF_SOFT_RESET) && pwdata_i[SOFT_RESET_BIT]) begin
      next_s.soft_reset_bit = 1'b1;
    end
    // sequencer
    unique case (s.seq)
      SEQ_POWER_DOWN: begin
        if (mode_wr && ((wcode == MODE_SINGLE) || (wcode == MODE_SELF_TEST))) begin
          next_s.seq = SEQ_MEASURE;
          next_s.mode = wcode;
          next_s.cont = 1'b0;
          next_s.self_test = (wcode == MODE_SELF_TEST);
        end else if (mode_wr && code_cont) begin
          next_s.seq = SEQ_MEASURE;
          next_s.mode = wcode;
          next_s.cont = 1'b1;
          next_s.rate = 3'(wcode[4:1] - 4'h1);
          next_s.restart = 1'b1;
          next_s.self_test = 1'b0;
        end
      end
      SEQ_MEASURE: begin
        if (stop_wr) begin
          next_s.seq = SEQ_POWER_DOWN;
          next_s.mode = MODE_POWER_DOWN;
          next_s.cont = 1'b0;
        end else if (mode_wr && code_cont && s.cont) begin
          next_s.mode = wcode;
          next_s.rate = 3'(wcode[4:1] - 4'h1);
          next_s.restart = 1'b1;
        end else if (meas_done_i) begin
          // apart from device reset, data is only touched when a result arrives
          if (next_s.reading) begin
            next_s.data_overrun_flag = 1'b1;
          end else begin
            if (next_s.data_ready_flag) begin
              next_s.data_overrun_flag = 1'b1;
            end
            next_s.data = meas_data_i;
            next_s.sensor_overflow_flag = (mag_sum >= OVERFLOW_COUNTS);
            next_s.data_ready_flag = 1'b1;
          end
          if (s.cont) begin
            next_s.seq = SEQ_SLEEP;
          end else begin
            next_s.seq = SEQ_POWER_DOWN;
            next_s.mode = MODE_POWER_DOWN;
            next_s.self_test = 1'b0;
          end
        end
      end
      SEQ_SLEEP: begin
        if (stop_wr) begin
          next_s.seq = SEQ_POWER_DOWN;
          next_s.mode = MODE_POWER_DOWN;
          next_s.cont = 1'b0;
        end else if (mode_wr && code_cont) begin
          next_s.seq = SEQ_MEASURE;
          next_s.mode = wcode;
          next_s.rate = 3'(wcode[4:1] - 4'h1);
          next_s.restart = 1'b1;
        end else if (fire) begin
          next_s.seq = SEQ_MEASURE;
        end
      end
    endcase
    // request drops one cycle on restart so the front end starts anew
    next_s.meas_req = (next_s.seq == SEQ_MEASURE) && !next_s.restart;
    next_s.sleep = (next_s.seq == SEQ_SLEEP);
    // device reset spares the bus answer so the master is not hung
    if (dev_rst) begin
      bus_prdata = next_s.prdata;
      bus_pready = next_s.pready;
      bus_pslverr = next_s.pslverr;
      next_s = CORE_RST;
      next_s.prdata = bus_prdata;
      next_s.pready = bus_pready;
      next_s.pslverr = bus_pslverr;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      s <= CORE_RST;
    end else begin
      s <= next_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign prdata_o = s.prdata;
  assign pready_o = s.pready;
  assign pslverr_o = s.pslverr;
  assign meas_req_o = s.meas_req;
  assign self_test_o = s.self_test;
  assign data_ready_pin_o = s.data_ready_flag;
  assign sleep_o = s.sleep;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);

  a_reset_pd: assert property (
    dev_rst |=> (s.seq == SEQ_POWER_DOWN) && (s.mode == MODE_POWER_DOWN) &&
      !data_ready_pin_o && !meas_req_o)
    else $error("reset did not return to power-down");

  a_pin_hold: assert property (
    (!reset_pin_n_i) [*3] |=> (s.seq == SEQ_POWER_DOWN) && !meas_req_o)
    else $error("device ran while reset pin low");

  a_single_end: assert property (
    (s.seq == SEQ_MEASURE) && !s.cont && meas_done_i && !mode_wr && !dev_rst &&
      !s.reading && !data_rd && !status2_rd
      |=> (s.mode == MODE_POWER_DOWN) && data_ready_pin_o && !meas_req_o)
    else $error("single measurement did not finish correctly");

  a_read_clear: assert property (
    (data_rd || status2_rd) && !meas_done_i |=> !s.data_ready_flag && !s.data_overrun_flag)
    else $error("read start did not clear flags");

  a_data_frozen: assert property (
    s.reading && !status2_rd && !dev_rst |=> $stable(s.data))
    else $error("protected data changed");

  a_overrun_set: assert property (
    (s.seq == SEQ_MEASURE) && meas_done_i && s.data_ready_flag && !s.reading &&
      !mode_wr && !data_rd && !status2_rd && !dev_rst
      |=> s.data_overrun_flag && data_ready_pin_o)
    else $error("overrun not flagged");

  a_cont_sleep: assert property (
    (s.seq == SEQ_MEASURE) && s.cont && meas_done_i && !mode_wr && !dev_rst
      |=> sleep_o && !meas_req_o)
    else $error("no sleep after continuous measurement");

  a_wake_fire: assert property (
    sleep_o && fire && !mode_wr && !dev_rst |=> meas_req_o ##1 meas_req_o)
    else $error("no wake on interval");

  a_ovf_eval: assert property (
    (s.seq == SEQ_MEASURE) && meas_done_i && !next_s.reading && !mode_wr && !dev_rst
      |=> s.sensor_overflow_flag == ($past(mag_sum) >= OVERFLOW_COUNTS))
    else $error("overflow flag wrong");

  a_apb_answer: assert property (
    psel_i && penable_i && !pready_o |=> pready_o ##1 !pready_o)
    else $error("apb answer not one cycle");

endmodule : mgs_seq

// ==== tb/mgs_front_end_model.sv ====
`timescale 1ns/10ps
module mgs_front_end_model (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // request and pacing
  input wire logic meas_req_i,
  input wire logic [7:0] delay_i,
  input wire mgs_pkg::mgs_sample_s sample_i,
  // answer
  output logic meas_done_o,
  output mgs_pkg::mgs_sample_s meas_data_o
);
  import mgs_pkg::*;

  logic [7:0] cnt;
  logic spent;

  ////////////////////////////////////////////////////////////////////////////
  // one result per request, after delay_i cycles; data toggles when not valid
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      cnt <= 8'h00;
      spent <= 1'b0;
      meas_done_o <= 1'b0;
      meas_data_o <= '0;
    end else begin
      meas_done_o <= 1'b0;
      meas_data_o <= ~meas_data_o;
      if (!meas_req_i) begin
        cnt <= 8'h00;
        spent <= 1'b0;
      end else if (!spent && cnt >= delay_i) begin
        meas_done_o <= 1'b1;
        meas_data_o <= sample_i;
        spent <= 1'b1;
      end else if (!spent) begin
        cnt <= cnt + 8'h01;
      end
    end
  end
endmodule : mgs_front_end_model

// ==== tb/test_magnetometer_mode_sequencer.sv ====
`timescale 1ns/10ps
module test_magnetometer_mode_sequencer;
  import mgs_pkg::*;

  localparam int unsigned TICKS = 10;
  logic clk_i, rst_n_i, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0] paddr, fe_delay;
  logic [31:0] pwdata, prdata, rd;
  logic [2:0] pins;
  logic meas_req, self_test, meas_done, ready_pin, sleep;
  logic [15:0] last_x;
  mgs_sample_s meas_data, sample, s1, s2, s3;
  int errors, n_tests, cyc, n;
  logic [2:0] causes [3] = '{3'h7, 3'h1, 3'h2};

  mgs_seq #(.TICK_CYCLES(TICKS)) mgs_seq_inst (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
    .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .core_supply_rise_i(pins[2]), .vid_ok_i(pins[1]), .reset_pin_n_i(pins[0]),
    .meas_req_o(meas_req), .self_test_o(self_test), .meas_done_i(meas_done),
    .meas_data_i(meas_data), .data_ready_pin_o(ready_pin), .sleep_o(sleep));
  mgs_front_end_model mgs_front_end_model_inst (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .meas_req_i(meas_req), .delay_i(fe_delay), .sample_i(sample),
    .meas_done_o(meas_done), .meas_data_o(meas_data));

  ////////////////////////////////////////////////////////////////////////////
  // clock and hang guard
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 80000) begin
      errors++;
      end_sim();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // compare, bus cycle and wait helpers
  task check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_i);
    penable <= 1'b1;
    // hold the request until the answer comes, the hang guard ends a stuck wait
    do begin
      @(posedge clk_i);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task rchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(rd, exp);
  endtask : rchk

  task wait_ready;
    do begin
      @(posedge clk_i);
    end while (ready_pin !== 1'b1);
  endtask : wait_ready

  task wait_done;
    do begin
      @(posedge clk_i);
    end while (meas_done !== 1'b1);
    @(posedge clk_i);
  endtask : wait_done

  task next_rise(output int c);
    c = 0;
    do begin
      @(posedge clk_i);
      c++;
    end while (meas_req !== 1'b0);
    do begin
      @(posedge clk_i);
      c++;
    end while (meas_req !== 1'b1);
  endtask : next_rise

  ////////////////////////////////////////////////////////////////////////////
  // expectation helpers
  function automatic int mag(logic [15:0] v);
    return v[15] ? 65536 - int'(v) : int'(v);
  endfunction : mag

  function automatic logic [31:0] ovf(mgs_sample_s s);
    return {28'h0, (mag(s.x) + mag(s.y) + mag(s.z)) >= OVERFLOW_COUNTS, 3'h0};
  endfunction : ovf

  function automatic mgs_sample_s rnd();
    return mgs_sample_s'({$urandom(), 24'($urandom())});
  endfunction : rnd

  task single(input logic [4:0] code, input mgs_sample_s s);
    sample <= s;
    fe_delay <= 8'($urandom_range(60, 30));
    apb(1'b1, OFF_MODE_CONTROL, {27'h0, code});
    @(posedge clk_i);
    check({31'h0, self_test}, {31'h0, code == MODE_SELF_TEST});
    rchk(OFF_FIRST_DATA, {16'h0, last_x});
    apb(1'b0, OFF_SECOND_STATUS, 32'h0);
    wait_ready();
    rchk(OFF_FIRST_STATUS, 32'h1);
    rchk(OFF_MODE_CONTROL, 32'h0);
    rchk(OFF_FIRST_DATA, {16'h0, s.x});
    rchk(OFF_Y_DATA, {16'h0, s.y});
    rchk(OFF_LAST_AXIS_DATA, {16'h0, s.z});
    rchk(OFF_LAST_DATA, {24'h0, s.temp});
    check({31'h0, ready_pin}, 32'h0);
    rchk(OFF_SECOND_STATUS, ovf(s));
    last_x = s.x;
  endtask : single

  task end_sim;
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : end_sim

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    pins = 3'h3;
    fe_delay = 8'd3;
    sample = '0;
    last_x = 16'h0;
    rst_n_i = 1'b0;
    void'($urandom(32'h8733DE9C));
    repeat (6) @(posedge clk_i);
    rst_n_i <= 1'b1;
    rchk(OFF_MODE_CONTROL, 32'h0);
    rchk(OFF_FIRST_STATUS, 32'h0);
    apb(1'b0, 8'h20, 32'h0);
    check({31'h0, err}, 32'h1);
    // singles: random, overflow boundary on both sides, then self-test
    single(MODE_SINGLE, rnd());
    single(MODE_SINGLE, mgs_sample_s'({16'hC180, 16'h3E80, 16'h02EB, 8'h5A}));
    single(MODE_SINGLE, mgs_sample_s'({16'hC180, 16'h3E80, 16'h02EA, 8'hA5}));
    single(MODE_SELF_TEST, rnd());
    // every continuous rate, measured rise to rise
    fe_delay <= 8'd3;
    for (int i = 0; i < RATE_COUNT; i++) begin
      apb(1'b1, OFF_MODE_CONTROL, {27'h0, MODE_CONT_FIRST + 5'(2 * i)});
      // first rise trails the restart gap, so time two steady rises
      next_rise(n);
      next_rise(n);
      next_rise(n);
      check(32'(n), PERIOD_MS[i] * TICKS);
      apb(1'b1, OFF_MODE_CONTROL, 32'h0);
      repeat (TICKS) @(posedge clk_i);
    end
    // unread result, then a read left open across a completion
    apb(1'b0, OFF_SECOND_STATUS, 32'h0);
    s1 = rnd();
    s2 = rnd();
    s3 = rnd();
    sample <= s1;
    apb(1'b1, OFF_MODE_CONTROL, 32'h0000000A);
    wait_ready();
    check({31'h0, sleep}, 32'h1);
    sample <= s2;
    wait_done();
    check({31'h0, sleep}, 32'h1);
    rchk(OFF_FIRST_STATUS, 32'h3);
    rchk(OFF_FIRST_DATA, {16'h0, s2.x});
    rchk(OFF_FIRST_STATUS, 32'h0);
    sample <= s3;
    wait_done();
    // status first: any data read starts a read and clears overrun
    rchk(OFF_FIRST_STATUS, 32'h2);
    rchk(OFF_Y_DATA, {16'h0, s2.y});
    rchk(OFF_SECOND_STATUS, ovf(s2));
    wait_done();
    apb(1'b1, OFF_MODE_CONTROL, 32'h0000000A);
    // the rewrite starts a new measurement at once
    next_rise(n);
    check({31'h0, n < 20}, 32'h1);
    rchk(OFF_FIRST_STATUS, 32'h1);
    rchk(OFF_LAST_AXIS_DATA, {16'h0, s3.z});
    apb(1'b0, OFF_SECOND_STATUS, 32'h0);
    // three reset pins, then the soft reset bit, each mid-run
    for (int j = 0; j < 4; j++) begin
      apb(1'b1, OFF_MODE_CONTROL, 32'h0000000A);
      if (j == 3) apb(1'b1, OFF_SOFT_RESET, 32'h1);
      else pins <= causes[j];
      repeat (8) @(posedge clk_i);
      check({31'h0, meas_req}, 32'h0);
      pins <= 3'h3;
      repeat (6) @(posedge clk_i);
      rchk(OFF_MODE_CONTROL, 32'h0);
      rchk(OFF_LAST_AXIS_DATA, 32'h0);
    end
    end_sim();
  end
endmodule : test_magnetometer_mode_sequencer
